// File: hdl/rapt_pkg.sv
// Constants, register map and field layout of the system timer block.
// Assumes a 32-bit AXI4-Lite slave port and one 125 MHz clock.
// Overview of operation
// - The clock counts only while the run enable is set, and that bit survives reset.
// - The 32-bit clock count register is readable, writable and always shows the count.
// - A maskable match interrupt rises as soon as the match register equals the count.
// - The match compares whole seconds and fires on entry to equality, whether by a second step or a count or match write.
// - The tick level field in bits 15:8 is the value the tick request output carries.
// - The tick flag sets when the down counter reaches zero and clears only on a written one.
// - The tick request output is driven only while tick flag and tick enable are both set.
// - With tick freeze halt set, the down counter stops while the freeze input is high.
// - The down counter runs only while its enable is one, holds when off, resets to one.
// - The 16-bit reload value is loaded into the down counter as its starting count.
// - A reload value of all ones gives the longest tick period.
// - The remaining count is read-only; writes are ignored and reads do not disturb it.
// - The second step divides 32.768 kHz or 38.4 kHz by the source select, kept over reset.
// - One hz and match flags set on their events, clear on a written one, and interrupt if enabled.
// - With clock freeze halt set, the clock stops while the freeze input is high.

package rapt_pkg;

   localparam int           ADDR_W     = 6;
   localparam int           DATA_W     = 32;
   localparam int           BYTE_LANES = 4;

   // Register byte addresses
   localparam logic [5:0]   REG_CLOCK_CTRL  = 6'h00;
   localparam logic [5:0]   REG_CLOCK_COUNT = 6'h04;
   localparam logic [5:0]   REG_WAKEUP      = 6'h08;
   localparam logic [5:0]   REG_TICK_CTRL   = 6'h0C;
   localparam logic [5:0]   REG_TICK_RELOAD = 6'h10;
   localparam logic [5:0]   REG_TICK_CUR    = 6'h14;
   localparam logic [5:0]   REG_IRQ_STATUS  = 6'h18;
   localparam logic [5:0]   REG_IRQ_CLEAR   = 6'h1C;
   localparam logic [5:0]   REG_IRQ_ENABLE  = 6'h20;

   // Clock control status fields
   localparam int           CC_LEVEL_LSB  = 8;
   localparam int           CC_ONE_HZ     = 7;
   localparam int           CC_MATCH      = 6;
   localparam int           CC_SRC_SEL    = 4;
   localparam int           CC_ONE_HZ_IE  = 3;
   localparam int           CC_MATCH_IE   = 2;
   localparam int           CC_FREEZE     = 1;
   localparam int           CC_RUN        = 0;

   // Tick control status fields
   localparam int           TC_LEVEL_LSB  = 8;
   localparam int           TC_FLAG       = 7;
   localparam int           TC_IRQ_EN     = 2;
   localparam int           TC_FREEZE     = 1;
   localparam int           TC_COUNT_EN   = 0;

   // Interrupt status bits
   localparam int           IRQ_ONE_HZ    = 0;
   localparam int           IRQ_MATCH     = 1;
   localparam int           IRQ_TICK      = 2;
   localparam int           IRQ_BITS      = 3;

   // Reset values
   localparam logic [15:0]  TICK_RELOAD_RST = 16'hFFFF;
   localparam logic         TICK_EN_RST     = 1'b1;

   // Reference edges per second
   localparam logic [15:0]  SEC_DIV_32K = 16'h8000;
   localparam logic [15:0]  SEC_DIV_38K = 16'h9600;

   // AXI responses
   localparam logic [1:0]   RESP_OKAY   = 2'h0;
   localparam logic [1:0]   RESP_SLVERR = 2'h2;

endpackage

// File: hdl/rapt_sec_div.sv
// One-second step divider counting reference edges.
// Assumes a one-cycle reference edge pulse on the system clock.
`timescale 1ns/10ps
`default_nettype none

module rapt_sec_div
   import rapt_pkg::*;
(
   input  wire logic i_clk,
   input  wire logic i_rstn,
   input  wire logic i_step,
   input  wire logic i_run,
   input  wire logic i_sel,
   output var  logic o_sec
);

   logic [15:0] edge_cnt;
   logic [15:0] limit;

   assign limit = i_sel ? SEC_DIV_38K : SEC_DIV_32K;

   // Divider holds while the clock is stopped
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         edge_cnt <= 16'h0000;
         o_sec    <= 1'b0;
      end else begin
         o_sec <= 1'b0;
         if (i_run && i_step) begin
            if (edge_cnt >= limit - 16'h0001) begin
               edge_cnt <= 16'h0000;
               o_sec    <= 1'b1;
            end else begin
               edge_cnt <= edge_cnt + 16'h0001;
            end
         end
      end
   end

endmodule

`default_nettype wire

// File: hdl/rapt_tick_cnt.sv
// Periodic modulus down counter with reload.
// Assumes steps arrive as one-cycle pulses on the system clock.
`timescale 1ns/10ps
`default_nettype none

module rapt_tick_cnt
   import rapt_pkg::*;
(
   input  wire logic        i_clk,
   input  wire logic        i_rstn,
   input  wire logic        i_step,
   input  wire logic        i_run,
   input  wire logic        i_load,
   input  wire logic [15:0] i_load_value,
   input  wire logic [15:0] i_reload,
   output var  logic [15:0] o_count,
   output var  logic        o_zero
);

   logic [15:0] next_count;

   assign next_count = (o_count == 16'h0000) ? i_reload : o_count - 16'h0001;

   // Period is reload plus one steps, so all ones is the longest
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_count <= TICK_RELOAD_RST;
         o_zero  <= 1'b0;
      end else begin
         o_zero <= 1'b0;
         if (i_load) begin
            o_count <= i_load_value;
         end else if (i_run && i_step) begin
            o_count <= next_count;
            o_zero  <= (next_count == 16'h0000);
         end
      end
   end

endmodule

`default_nettype wire

// File: hdl/rapt_top.sv
// Top of the system timer: seconds clock with match compare, periodic
// tick counter and an AXI4-Lite register slave.
// Assumes i_ref_clk and i_freeze are asynchronous pins; one write and
// one read at most in flight.
//
// The AXI4-Lite slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none

module rapt_top
   import rapt_pkg::*;
(
   input  wire logic              i_clk,
   input  wire logic              i_resetn,
   input  wire logic              i_ref_clk,
   input  wire logic              i_freeze,
   input  wire logic [ADDR_W-1:0] i_awaddr,
   input  wire logic              i_awvalid,
   output var  logic              o_awready,
   input  wire logic [DATA_W-1:0] i_wdata,
   input  wire logic [3:0]        i_wstrb,
   input  wire logic              i_wvalid,
   output var  logic              o_wready,
   output var  logic [1:0]        o_bresp,
   output var  logic              o_bvalid,
   input  wire logic              i_bready,
   input  wire logic [ADDR_W-1:0] i_araddr,
   input  wire logic              i_arvalid,
   output var  logic              o_arready,
   output var  logic [DATA_W-1:0] o_rdata,
   output var  logic [1:0]        o_rresp,
   output var  logic              o_rvalid,
   input  wire logic              i_rready,
   output var  logic              o_irq,
   output var  logic [7:0]        o_tick_irq_req,
   output var  logic [7:0]        o_clock_irq_req
);

   logic                rst_meta;
   logic                rst_n;
   logic                ref_meta;
   logic                ref_sync;
   logic                ref_last;
   logic                ref_step;
   logic                frz_meta;
   logic                frz_sync;
   logic                aw_got;
   logic                w_got;
   logic [ADDR_W-1:0]   wr_addr;
   logic [DATA_W-1:0]   wr_data;
   logic [DATA_W-1:0]   wr_mask;
   logic [3:0]          wr_strb;
   logic                wr_en;
   logic [DATA_W-1:0]   wr_bits;
   logic                wr_mapped;
   logic                rd_mapped;
   logic [DATA_W-1:0]   rd_value;
   logic [7:0]          clock_irq_level;
   logic                one_hz_flag;
   logic                match_flag;
   logic                clock_source_select = 1'b0;
   logic                clock_run_enable    = 1'b0;
   logic                one_hz_irq_enable;
   logic                match_irq_enable;
   logic                clock_freeze_halt;
   logic [31:0]         clock_count_value;
   logic [31:0]         wakeup_match_reg;
   logic                eq_last;
   logic                match_evt;
   logic                sec_pulse;
   logic                sec_step;
   logic                rtc_run;
   logic [7:0]          tick_irq_level;
   logic                tick_flag;
   logic                tick_irq_enable;
   logic                tick_freeze_halt;
   logic                tick_count_enable;
   logic [15:0]         tick_reload_value;
   logic [15:0]         tick_remaining;
   logic                tick_zero;
   logic                tick_run;
   logic [IRQ_BITS-1:0] irq_status;
   logic [IRQ_BITS-1:0] irq_enable;
   logic [IRQ_BITS-1:0] irq_set;
   logic [31:0]         clock_ctrl_status;
   logic [31:0]         tick_ctrl_status;
   logic [31:0]         next_clock_ctrl;
   logic [31:0]         next_tick_ctrl;
   logic [31:0]         next_count;
   logic [31:0]         next_wakeup;
   logic [31:0]         next_reload;
   logic [31:0]         next_enable;
   logic                hit_cc;
   logic                hit_count;
   logic                hit_wake;
   logic                hit_tc;
   logic                hit_reload;
   logic                hit_clear;
   logic                hit_enable;

   // Reset released through two flops, asserted at once
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   // Pin synchronisers; edge taken only from the second stage
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         ref_meta <= 1'b0;
         ref_sync <= 1'b0;
         ref_last <= 1'b0;
         frz_meta <= 1'b0;
         frz_sync <= 1'b0;
      end else begin
         ref_meta <= i_ref_clk;
         ref_sync <= ref_meta;
         ref_last <= ref_sync;
         frz_meta <= i_freeze;
         frz_sync <= frz_meta;
      end
   end

   assign ref_step = ref_sync & ~ref_last;

   assign rtc_run  = clock_run_enable & ~(clock_freeze_halt & frz_sync);
   assign tick_run = tick_count_enable & ~(tick_freeze_halt & frz_sync);
   assign sec_step = sec_pulse & rtc_run;

   rapt_sec_div u_sec_div (
      .i_clk  (i_clk),
      .i_rstn (rst_n),
      .i_step (ref_step),
      .i_run  (rtc_run),
      .i_sel  (clock_source_select),
      .o_sec  (sec_pulse)
   );

   rapt_tick_cnt u_tick_cnt (
      .i_clk        (i_clk),
      .i_rstn       (rst_n),
      .i_step       (ref_step),
      .i_run        (tick_run),
      .i_load       (hit_reload),
      .i_load_value (next_reload[15:0]),
      .i_reload     (tick_reload_value),
      .o_count      (tick_remaining),
      .o_zero       (tick_zero)
   );

   // Byte enables widened to a bit mask
   for (genvar b = 0; b < BYTE_LANES; b++) begin : g_mask
      assign wr_mask[8*b +: 8] = {8{wr_strb[b]}};
   end

   // Write side: address and data taken in either order
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_awready <= 1'b0;
         o_wready  <= 1'b0;
         aw_got    <= 1'b0;
         w_got     <= 1'b0;
         wr_addr   <= '0;
         wr_data   <= '0;
         wr_strb   <= 4'h0;
         o_bvalid  <= 1'b0;
         o_bresp   <= RESP_OKAY;
      end else begin
         if (i_awvalid && o_awready) begin
            o_awready <= 1'b0;
            aw_got    <= 1'b1;
            wr_addr   <= i_awaddr;
         end else if (!aw_got && !o_bvalid) begin
            o_awready <= 1'b1;
         end
         if (i_wvalid && o_wready) begin
            o_wready <= 1'b0;
            w_got    <= 1'b1;
            wr_data  <= i_wdata;
            wr_strb  <= i_wstrb;
         end else if (!w_got && !o_bvalid) begin
            o_wready <= 1'b1;
         end
         if (wr_en) begin
            aw_got   <= 1'b0;
            w_got    <= 1'b0;
            o_bvalid <= 1'b1;
            o_bresp  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
         end else if (o_bvalid && i_bready) begin
            o_bvalid <= 1'b0;
         end
      end
   end

   assign wr_en      = aw_got & w_got & ~o_bvalid;
   assign wr_bits    = wr_data & wr_mask;
   assign hit_cc     = wr_en && (wr_addr == REG_CLOCK_CTRL);
   assign hit_count  = wr_en && (wr_addr == REG_CLOCK_COUNT);
   assign hit_wake   = wr_en && (wr_addr == REG_WAKEUP);
   assign hit_tc     = wr_en && (wr_addr == REG_TICK_CTRL);
   assign hit_reload = wr_en && (wr_addr == REG_TICK_RELOAD);
   assign hit_clear  = wr_en && (wr_addr == REG_IRQ_CLEAR);
   assign hit_enable = wr_en && (wr_addr == REG_IRQ_ENABLE);
   assign wr_mapped  = hit_cc | hit_count | hit_wake | hit_tc | hit_reload | hit_clear
                       | hit_enable | (wr_addr == REG_TICK_CUR) | (wr_addr == REG_IRQ_STATUS);

   // Register images as software sees them
   assign clock_ctrl_status = {16'h0000, clock_irq_level, one_hz_flag, match_flag, 1'b0,
                               clock_source_select, one_hz_irq_enable, match_irq_enable,
                               clock_freeze_halt, clock_run_enable};
   // unused bits never stored, read as zero
   assign tick_ctrl_status  = {16'h0000, tick_irq_level, tick_flag, 4'h0,
                               tick_irq_enable, tick_freeze_halt, tick_count_enable};

   // Byte-lane merge of old value and written bits
   assign next_clock_ctrl = (clock_ctrl_status & ~wr_mask) | wr_bits;
   assign next_tick_ctrl  = (tick_ctrl_status & ~wr_mask) | wr_bits;
   assign next_count      = (clock_count_value & ~wr_mask) | wr_bits;
   assign next_wakeup     = (wakeup_match_reg & ~wr_mask) | wr_bits;
   assign next_reload     = ({16'h0000, tick_reload_value} & ~wr_mask) | wr_bits;
   assign next_enable     = ({29'h0, irq_enable} & ~wr_mask) | wr_bits;

   // bits with no reset, kept across a reset pulse
   always_ff @(posedge i_clk) begin
      if (hit_cc) begin
         clock_run_enable    <= next_clock_ctrl[CC_RUN];
         clock_source_select <= next_clock_ctrl[CC_SRC_SEL];
      end
   end

   // Clock controls, count and match register
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         clock_irq_level   <= 8'h00;
         one_hz_irq_enable <= 1'b0;
         match_irq_enable  <= 1'b0;
         clock_freeze_halt <= 1'b0;
         clock_count_value <= 32'h0000_0000;
         wakeup_match_reg  <= 32'h0000_0000;
      end else begin
         if (hit_cc) begin
            clock_irq_level   <= next_clock_ctrl[CC_LEVEL_LSB +: 8];
            one_hz_irq_enable <= next_clock_ctrl[CC_ONE_HZ_IE];
            match_irq_enable  <= next_clock_ctrl[CC_MATCH_IE];
            clock_freeze_halt <= next_clock_ctrl[CC_FREEZE];
         end
         // software write beats the second step
         if (hit_count) begin
            clock_count_value <= next_count;
         end else if (sec_step) begin
            clock_count_value <= clock_count_value + 32'h0000_0001;
         end
         if (hit_wake) begin
            wakeup_match_reg <= next_wakeup;
         end
      end
   end

   // match fires on entry to equality only
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         eq_last <= 1'b1;
      end else begin
         eq_last <= (clock_count_value == wakeup_match_reg);
      end
   end

   assign match_evt = (clock_count_value == wakeup_match_reg) & ~eq_last;

   // clock flags, set wins over a written one
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         one_hz_flag <= 1'b0;
         match_flag  <= 1'b0;
      end else begin
         one_hz_flag <= (one_hz_flag & ~(hit_cc & wr_bits[CC_ONE_HZ])) | sec_step;
         match_flag  <= (match_flag & ~(hit_cc & wr_bits[CC_MATCH])) | match_evt;
      end
   end

   // Tick controls and reload value
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         tick_irq_level    <= 8'h00;
         tick_irq_enable   <= 1'b0;
         tick_freeze_halt  <= 1'b0;
         tick_count_enable <= TICK_EN_RST;
         tick_reload_value <= TICK_RELOAD_RST;
      end else begin
         if (hit_tc) begin
            tick_irq_level    <= next_tick_ctrl[TC_LEVEL_LSB +: 8];
            tick_irq_enable   <= next_tick_ctrl[TC_IRQ_EN];
            tick_freeze_halt  <= next_tick_ctrl[TC_FREEZE];
            tick_count_enable <= next_tick_ctrl[TC_COUNT_EN];
         end
         if (hit_reload) begin
            tick_reload_value <= next_reload[15:0];
         end
      end
   end

   // tick flag, event wins over the clear
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         tick_flag <= 1'b0;
      end else begin
         tick_flag <= (tick_flag & ~(hit_tc & wr_bits[TC_FLAG])) | tick_zero;
      end
   end

   // Summary status, clear and enable; set wins over clear
   assign irq_set = {tick_zero, match_evt, sec_step};

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_status <= '0;
         irq_enable <= '0;
      end else begin
         irq_status <= (irq_status & ~({IRQ_BITS{hit_clear}} & wr_bits[IRQ_BITS-1:0])) | irq_set;
         if (hit_enable) begin
            irq_enable <= next_enable[IRQ_BITS-1:0];
         end
      end
   end

   // Interrupt outputs; one cycle behind the flags
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_irq           <= 1'b0;
         o_tick_irq_req  <= 8'h00;
         o_clock_irq_req <= 8'h00;
      end else begin
         o_irq           <= |(irq_status & irq_enable);
         o_tick_irq_req  <= (tick_flag & tick_irq_enable) ? tick_irq_level : 8'h00;
         o_clock_irq_req <= ((one_hz_flag & one_hz_irq_enable) | (match_flag & match_irq_enable))
                            ? clock_irq_level : 8'h00;
      end
   end

   // Read mux; reads have no side effects
   always_comb begin
      rd_mapped = 1'b1;
      rd_value  = 32'h0000_0000;
      case (i_araddr)
         REG_CLOCK_CTRL  : rd_value = clock_ctrl_status;
         REG_CLOCK_COUNT : rd_value = clock_count_value;
         REG_WAKEUP      : rd_value = wakeup_match_reg;
         REG_TICK_CTRL   : rd_value = tick_ctrl_status;
         REG_TICK_RELOAD : rd_value = {16'h0000, tick_reload_value};
         REG_TICK_CUR    : rd_value = {16'h0000, tick_remaining};
         REG_IRQ_STATUS  : rd_value = {29'h0, irq_status};
         REG_IRQ_CLEAR   : rd_value = 32'h0000_0000;
         REG_IRQ_ENABLE  : rd_value = {29'h0, irq_enable};
         default         : rd_mapped = 1'b0;
      endcase
   end

   // Read side: data one cycle after the address is taken
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_arready <= 1'b0;
         o_rvalid  <= 1'b0;
         o_rdata   <= 32'h0000_0000;
         o_rresp   <= RESP_OKAY;
      end else begin
         if (i_arvalid && o_arready) begin
            o_arready <= 1'b0;
            o_rvalid  <= 1'b1;
            o_rdata   <= rd_value;
            o_rresp   <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
         end else if (o_rvalid && i_rready) begin
            o_rvalid <= 1'b0;
         end else if (!o_rvalid) begin
            o_arready <= 1'b1;
         end
      end
   end

endmodule

`default_nettype wire

// File: verif/rapt_chk.sv
// Checker for the timer register port handshakes and read answers.
// Assumes it is bound onto rapt_top; one clock, reset active low.
`timescale 1ns/10ps
`default_nettype none

module rapt_chk
   import rapt_pkg::*;
(
   input  wire logic              i_clk,
   input  wire logic              i_resetn,
   input  wire logic [ADDR_W-1:0] i_araddr,
   input  wire logic              i_awvalid,
   input  wire logic              o_awready,
   input  wire logic              i_wvalid,
   input  wire logic              o_wready,
   input  wire logic              o_bvalid,
   input  wire logic              i_bready,
   input  wire logic              i_arvalid,
   input  wire logic              o_arready,
   input  wire logic [DATA_W-1:0] o_rdata,
   input  wire logic [1:0]        o_rresp,
   input  wire logic              o_rvalid,
   input  wire logic              i_rready
);
   // Reset pin gates every property; the two-cycle synced release is not gated
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_resetn);
   sequence s_ar;
      i_arvalid && o_arready;
   endsequence
   sequence s_bad;
      s_ar ##0 (i_araddr > REG_IRQ_ENABLE);
   endsequence
   sequence s_cur;
      s_ar ##0 (i_araddr == REG_TICK_CUR);
   endsequence
   // Both write channels taken in one cycle; commit cycle comes before bvalid
   sequence s_wr_both;
      i_awvalid && o_awready && i_wvalid && o_wready;
   endsequence
   a_b_answer: assert property (s_wr_both |=> !o_bvalid ##1 o_bvalid)
      else $error("write response late");
   a_b_drop: assert property (o_bvalid && i_bready |=> !o_bvalid)
      else $error("write response stuck");
   a_r_answer: assert property (s_ar |=> o_rvalid)
      else $error("read answer late");
   a_r_drop: assert property (o_rvalid && i_rready |=> !o_rvalid)
      else $error("read answer stuck");
   a_aw_drop: assert property (i_awvalid && o_awready |=> !o_awready)
      else $error("awready kept high");
   a_ar_drop: assert property (s_ar |=> !o_arready)
      else $error("arready kept high");
   a_bad_addr: assert property (s_bad |=> o_rresp == RESP_SLVERR && o_rdata == 32'h0)
      else $error("unmapped read answered");
   a_cur_width: assert property (s_cur |=> o_rdata[31:16] == 16'h0000)
      else $error("remaining count too wide");
endmodule

bind rapt_top rapt_chk u_chk (.i_clk, .i_resetn, .i_araddr, .i_awvalid, .o_awready,
   .i_wvalid, .o_wready, .o_bvalid, .i_bready, .i_arvalid, .o_arready, .o_rdata,
   .o_rresp, .o_rvalid, .i_rready);
`default_nettype wire

// File: verif/tb_rapt_top.sv
// Bench for the system timer: register scenarios over AXI4-Lite.
// Assumes the bench paces the reference pin itself, four clocks a level.
`timescale 1ns/10ps
`default_nettype none

module tb_rapt_top
   import rapt_pkg::*;
;
   logic              i_clk = 1'b0, i_resetn = 1'b0, i_ref_clk = 1'b0, i_freeze = 1'b0;
   logic [ADDR_W-1:0] i_awaddr = '0, i_araddr = '0;
   logic [DATA_W-1:0] i_wdata = '0, o_rdata, rv;
   logic [3:0]        i_wstrb = 4'hF;
   logic              i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0;
   logic              i_arvalid = 1'b0, i_rready = 1'b0;
   logic [1:0]        o_bresp, o_rresp, rr;
   logic              o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_irq;
   logic [7:0]        o_tick_irq_req, o_clock_irq_req;
   int                n_errors = 0, check_count = 0;

   rapt_top dut (.i_clk, .i_resetn, .i_ref_clk, .i_freeze, .i_awaddr, .i_awvalid,
      .o_awready, .i_wdata, .i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready,
      .i_araddr, .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready, .o_irq,
      .o_tick_irq_req, .o_clock_irq_req);

   always #4 i_clk = ~i_clk;

   task automatic chk(input logic [31:0] s, input logic [31:0] e, input string nm);
      check_count++;
      if (s !== e) begin
         n_errors++;
         $display("MISMATCH %s exp %h seen %h", nm, e, s);
      end
   endtask
   // Each channel drops only at its own handshake edge
   task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge i_clk);
      i_awaddr <= a;
      i_wdata <= d;
      i_awvalid <= 1'b1;
      i_wvalid <= 1'b1;
      i_bready <= 1'b1;
      forever begin
         @(posedge i_clk);
         if (i_awvalid && o_awready) i_awvalid <= 1'b0;
         if (i_wvalid && o_wready) i_wvalid <= 1'b0;
         if (o_bvalid) break;
      end
      i_bready <= 1'b0;
      chk({30'h0, o_bresp}, {30'h0, er}, "bresp");
   endtask
   task automatic rd(input logic [5:0] a, input logic [31:0] e, input logic [1:0] er,
                     input string nm);
      @(posedge i_clk);
      i_araddr <= a;
      i_arvalid <= 1'b1;
      i_rready <= 1'b1;
      forever begin
         @(posedge i_clk);
         if (i_arvalid && o_arready) i_arvalid <= 1'b0;
         if (o_rvalid) break;
      end
      rv = o_rdata;
      rr = o_rresp;
      i_rready <= 1'b0;
      chk(rv, e, nm);
      chk({30'h0, rr}, {30'h0, er}, "rresp");
   endtask
   // Slow reference edges, with settle time for the two-flop sync
   task automatic step(input int n);
      repeat (n) begin
         i_ref_clk <= 1'b1;
         repeat (4) @(posedge i_clk);
         i_ref_clk <= 1'b0;
         repeat (4) @(posedge i_clk);
      end
      repeat (4) @(posedge i_clk);
   endtask
   task automatic rst();
      @(posedge i_clk);
      i_resetn <= 1'b0;
      repeat (2) @(posedge i_clk);
      i_resetn <= 1'b1;
      repeat (4) @(posedge i_clk);
   endtask
   task automatic irq(input logic e);
      repeat (2) @(posedge i_clk);
      chk({31'h0, o_irq}, {31'h0, e}, "irq");
   endtask
   task automatic results();
      if (n_errors == 0 && check_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // Main sequence
   initial begin
      rst();
      rd(REG_TICK_CTRL, 32'h1, RESP_OKAY, "tctl");
      rd(REG_TICK_RELOAD, 32'hFFFF, RESP_OKAY, "reload");
      rd(REG_TICK_CUR, 32'hFFFF, RESP_OKAY, "cur");
      rd(6'h24, 32'h0, RESP_SLVERR, "bad");
      wr(6'h24, 32'h1, RESP_SLVERR);
      wr(REG_TICK_RELOAD, 32'h3, RESP_OKAY);
      rd(REG_TICK_CUR, 32'h3, RESP_OKAY, "cur");
      wr(REG_TICK_CUR, 32'h0, RESP_OKAY);
      rd(REG_TICK_CUR, 32'h3, RESP_OKAY, "cur");
      wr(REG_TICK_CTRL, 32'h0500, RESP_OKAY);
      step(2);
      rd(REG_TICK_CUR, 32'h3, RESP_OKAY, "cur");
      wr(REG_TICK_CTRL, 32'h0507, RESP_OKAY);
      i_freeze <= 1'b1;
      step(2);
      rd(REG_TICK_CUR, 32'h3, RESP_OKAY, "cur");
      i_freeze <= 1'b0;
      wr(REG_TICK_CTRL, 32'h0505, RESP_OKAY);
      step(1);
      rd(REG_TICK_CUR, 32'h2, RESP_OKAY, "cur");
      step(2);
      rd(REG_TICK_CTRL, 32'h0585, RESP_OKAY, "tctl");
      chk({24'h0, o_tick_irq_req}, 32'h5, "treq");
      step(1);
      rd(REG_TICK_CUR, 32'h3, RESP_OKAY, "cur");
      irq(1'b0);
      wr(REG_IRQ_ENABLE, 32'h4, RESP_OKAY);
      irq(1'b1);
      wr(REG_TICK_CTRL, 32'h0505, RESP_OKAY);
      rd(REG_TICK_CTRL, 32'h0585, RESP_OKAY, "tctl");
      wr(REG_TICK_CTRL, 32'h0585, RESP_OKAY);
      rd(REG_TICK_CTRL, 32'h0505, RESP_OKAY, "tctl");
      chk({24'h0, o_tick_irq_req}, 32'h0, "treq");
      wr(REG_IRQ_CLEAR, 32'h4, RESP_OKAY);
      irq(1'b0);
      wr(REG_CLOCK_COUNT, 32'h5, RESP_OKAY);
      rd(REG_CLOCK_COUNT, 32'h5, RESP_OKAY, "count");
      wr(REG_CLOCK_CTRL, 32'h0304, RESP_OKAY);
      wr(REG_WAKEUP, 32'h5, RESP_OKAY);
      rd(REG_CLOCK_CTRL, 32'h0344, RESP_OKAY, "cctl");
      chk({24'h0, o_clock_irq_req}, 32'h3, "creq");
      rd(REG_IRQ_STATUS, 32'h2, RESP_OKAY, "stat");
      wr(REG_CLOCK_CTRL, 32'h0344, RESP_OKAY);
      rd(REG_CLOCK_CTRL, 32'h0304, RESP_OKAY, "cctl");
      wr(REG_CLOCK_CTRL, 32'h0011, RESP_OKAY);
      rst();
      rd(REG_CLOCK_CTRL, 32'h0011, RESP_OKAY, "cctl");
      results();
   end

   // Watchdog well beyond the few hundred cycles the tests need
   initial begin
      repeat (20000) @(posedge i_clk);
      n_errors++;
      results();
   end
endmodule
`default_nettype wire
